// ==== hw/bcte_engine.sv ====
// Block chain transfer engine: fetches transfer information through a vector table,
// moves data over the system bus, writes information back and chains or interrupts.
// Assumes a bus that answers each request with a one-cycle MEM_ACK_I and startup
// requests made by same-clock logic.
`timescale 1ns/1ns
`include "bcte_params.svh"
module bcte_engine (
	// Clock and reset
	input wire logic CLOCK_I,
	input wire logic RST_B_I,
	// Register port
	input wire logic [7:0] REG_ADDR_I,
	input wire logic [31:0] REG_WDATA_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	output logic [31:0] REG_RDATA_O,
	// Startup requests
	input wire logic STARTUP_REQ_I,
	input wire logic [7:0] VECTOR_I,
	output logic REQ_FULL_O,
	// System bus master
	output bcte_pkg::bcte_bus_t MEM_O,
	input wire logic MEM_ACK_I,
	input wire logic [31:0] MEM_RDATA_I,
	// Interrupt source handling
	output logic CPU_IRQ_O,
	output logic FLAG_CLR_O
);
	bcte_pkg::bcte_state_t state_r;
	bcte_pkg::bcte_state_t gap_to_r;
	bcte_pkg::bcte_mra_t mra_r;
	bcte_pkg::bcte_mrb_t mrb_r;
	logic [31:0] vtb_r;
	logic [2:0] ctrl_r;
	logic pending_r;
	logic [7:0] pend_vec_r;
	logic [7:0] cur_vec_r;
	logic [7:0] prev_vec_r;
	logic prev_ok_r;
	logic skip_r;
	logic chained_r;
	logic hit_r;
	logic first_r;
	logic [1:0] idx_r;
	logic [1:0] int_cnt_r;
	logic [8:0] elem_r;
	logic [31:0] info_base_r;
	logic [31:0] sar_r;
	logic [31:0] dar_r;
	logic [31:0] sar0_r;
	logic [31:0] dar0_r;
	logic [15:0] cra_r;
	logic [15:0] crb_r;
	logic [31:0] data_r;
	logic take;
	logic short_mode;
	logic [1:0] md;
	logic is_block;
	logic [7:0] count_a_low;
	logic [7:0] count_a_reload;
	logic [8:0] elem_init;
	logic [31:0] sar_step;
	logic [31:0] dar_step;
	logic area_wrap;
	logic count_hit;
	logic link_go;
	logic end_irq;

	function automatic logic [31:0] step_addr(input logic [31:0] a, input logic [1:0] am,
		input logic [1:0] sz);
		logic [31:0] st;
		st = (sz == `BCTE_SZ_BYTE) ? `BCTE_STEP_BYTE :
			(sz == `BCTE_SZ_WORD) ? `BCTE_STEP_WORD : `BCTE_STEP_LONG;
		case (am)
			`BCTE_AM_INC: step_addr = a + st;
			`BCTE_AM_DEC: step_addr = a - st;
			default: step_addr = a;
		endcase
	endfunction : step_addr

	assign short_mode = ctrl_r[`BCTE_CTRL_SHORT];
	assign md = mra_r.transfer_mode_field;
	assign is_block = (md == `BCTE_MD_BLOCK);
	assign count_a_low = cra_r[7:0];
	assign count_a_reload = cra_r[15:8];
	// A zero block size stands for the full 256 elements.
	assign elem_init = !is_block ? 9'h001 : (~|count_a_low) ? `BCTE_BLK_FULL : {1'b0, count_a_low};
	assign sar_step = step_addr(sar_r, mra_r.source_addr_mode, mra_r.element_size);
	assign dar_step = step_addr(dar_r, mrb_r.dest_addr_mode, mra_r.element_size);
	assign area_wrap = is_block || (md == `BCTE_MD_REPEAT && count_a_low == 8'h01);
	// Normal count 1 to 0 ends; a loaded zero wraps to FFFF and runs 65536 times.
	assign count_hit = is_block ? (crb_r == 16'h0001) :
		(md == `BCTE_MD_REPEAT) ? (count_a_low == 8'h01) : (cra_r == 16'h0001);
	assign link_go = mrb_r.link_enable && (!mrb_r.link_on_zero || hit_r);
	// Repeat counts reload instead of reaching zero, so they never interrupt on count.
	assign end_irq = (hit_r && md != `BCTE_MD_REPEAT) || mrb_r.irq_every_transfer;
	assign take = (state_r == bcte_pkg::S_IDLE) && ctrl_r[`BCTE_CTRL_RUN] && pending_r;

	// Software registers.
	always_ff @(posedge CLOCK_I) begin
		if (!RST_B_I) begin
			vtb_r <= 32'h0;
			ctrl_r <= 3'h0;
		end else if (REG_WR_I) begin
			if (REG_ADDR_I == `BCTE_REG_VTB)
				vtb_r <= REG_WDATA_I & `BCTE_ALIGN_MASK;
			if (REG_ADDR_I == `BCTE_REG_CTRL)
				ctrl_r <= REG_WDATA_I[2:0];
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (!RST_B_I) begin
			REG_RDATA_O <= 32'h0;
		end else if (REG_RD_I) begin
			case (REG_ADDR_I)
				`BCTE_REG_VTB: REG_RDATA_O <= vtb_r;
				`BCTE_REG_CTRL: REG_RDATA_O <= {29'h0, ctrl_r};
				`BCTE_REG_STAT: REG_RDATA_O <= {13'h0, state_r != bcte_pkg::S_IDLE,
					pending_r, prev_ok_r, prev_vec_r, cur_vec_r};
				default: REG_RDATA_O <= 32'h0;
			endcase
		end else begin
			REG_RDATA_O <= 32'h0;
		end
	end

	// One pending slot; an arrival in the take cycle refills it rather than being lost.
	always_ff @(posedge CLOCK_I) begin
		if (!RST_B_I) begin
			pending_r <= 1'b0;
			pend_vec_r <= 8'h0;
		end else if (STARTUP_REQ_I && (!pending_r || take)) begin
			pending_r <= 1'b1;
			pend_vec_r <= VECTOR_I;
		end else if (take) begin
			pending_r <= 1'b0;
		end
	end
	assign REQ_FULL_O = pending_r;

	// Sequencer, bus master and working copy of the transfer information.
	always_ff @(posedge CLOCK_I) begin
		if (!RST_B_I) begin
			state_r <= bcte_pkg::S_IDLE;
			gap_to_r <= bcte_pkg::S_IDLE;
			MEM_O <= '0;
			mra_r <= '0;
			mrb_r <= '0;
			cur_vec_r <= 8'h0;
			prev_vec_r <= 8'h0;
			prev_ok_r <= 1'b0;
			skip_r <= 1'b0;
			chained_r <= 1'b0;
			hit_r <= 1'b0;
			first_r <= 1'b0;
			idx_r <= 2'h0;
			int_cnt_r <= 2'h0;
			elem_r <= 9'h0;
			info_base_r <= 32'h0;
			sar_r <= 32'h0;
			dar_r <= 32'h0;
			sar0_r <= 32'h0;
			dar0_r <= 32'h0;
			cra_r <= 16'h0;
			crb_r <= 16'h0;
			data_r <= 32'h0;
			CPU_IRQ_O <= 1'b0;
			FLAG_CLR_O <= 1'b0;
		end else begin
			CPU_IRQ_O <= 1'b0;
			FLAG_CLR_O <= 1'b0;
			if (!ctrl_r[`BCTE_CTRL_RRS])
				prev_ok_r <= 1'b0;
			case (state_r)
				bcte_pkg::S_IDLE: begin
					chained_r <= 1'b0;
					if (take) begin
						cur_vec_r <= pend_vec_r;
						if (ctrl_r[`BCTE_CTRL_RRS] && prev_ok_r && pend_vec_r == prev_vec_r) begin
							skip_r <= 1'b1;
							elem_r <= elem_init;
							first_r <= 1'b1;
							state_r <= bcte_pkg::S_DRD;
						end else begin
							skip_r <= 1'b0;
							state_r <= bcte_pkg::S_VEC;
						end
					end
				end
				bcte_pkg::S_VEC: begin
					if (!MEM_O.req) begin
						MEM_O <= {1'b1, 1'b0, 1'b1, `BCTE_SZ_LONG, vtb_r + {22'h0, cur_vec_r, 2'b00},
							32'h0};
					end else if (MEM_ACK_I) begin
						MEM_O.req <= 1'b0;
						info_base_r <= MEM_RDATA_I & `BCTE_ALIGN_MASK;
						idx_r <= 2'h0;
						gap_to_r <= bcte_pkg::S_INFO;
						state_r <= bcte_pkg::S_GAP;
					end
				end
				bcte_pkg::S_INFO: begin
					if (!MEM_O.req) begin
						MEM_O <= {1'b1, 1'b0, 1'b1, `BCTE_SZ_LONG, info_base_r + {28'h0, idx_r, 2'b00},
							32'h0};
					end else if (MEM_ACK_I) begin
						MEM_O.req <= 1'b0;
						if (short_mode) begin
							case (idx_r)
								2'h0: {mra_r, sar_r} <= {MEM_RDATA_I[31:24], 8'h0, MEM_RDATA_I[23:0]};
								2'h1: {mrb_r, dar_r} <= {MEM_RDATA_I[31:24], 8'h0, MEM_RDATA_I[23:0]};
								default: {cra_r, crb_r} <= MEM_RDATA_I;
							endcase
						end else begin
							case (idx_r)
								2'h0: {mra_r, mrb_r} <= MEM_RDATA_I[31:16];
								2'h1: sar_r <= MEM_RDATA_I;
								2'h2: dar_r <= MEM_RDATA_I;
								default: {cra_r, crb_r} <= MEM_RDATA_I;
							endcase
						end
						if (idx_r == (short_mode ? `BCTE_SHORT_LAST : `BCTE_FULL_LAST)) begin
							gap_to_r <= bcte_pkg::S_DRD;
							state_r <= bcte_pkg::S_GAP;
						end else begin
							idx_r <= idx_r + 2'h1;
						end
					end
				end
				bcte_pkg::S_GAP: begin
					// Element count is set here since the count word has only just landed.
					if (gap_to_r == bcte_pkg::S_DRD && !first_r && elem_r == 9'h0) begin
						elem_r <= elem_init;
						first_r <= 1'b1;
					end
					state_r <= gap_to_r;
				end
				bcte_pkg::S_DRD: begin
					if (first_r && !MEM_O.req) begin
						first_r <= 1'b0;
						// Area start is caught at the top of a block or repeat round, or in normal mode when count A's low and reload bytes match.
						if (is_block || count_a_low == count_a_reload) begin
							sar0_r <= sar_r;
							dar0_r <= dar_r;
						end
					end
					if (!MEM_O.req) begin
						MEM_O <= {1'b1, 1'b0, 1'b0, mra_r.element_size, sar_r, 32'h0};
					end else if (MEM_ACK_I) begin
						MEM_O.req <= 1'b0;
						data_r <= MEM_RDATA_I;
						gap_to_r <= bcte_pkg::S_DWR;
						// Multi-element blocks stream reads without the extra clock.
						state_r <= (is_block && elem_init != 9'h001) ? bcte_pkg::S_DWR
							: bcte_pkg::S_GAP;
					end
				end
				bcte_pkg::S_DWR: begin
					if (!MEM_O.req) begin
						MEM_O <= {1'b1, 1'b1, 1'b0, mra_r.element_size, dar_r, data_r};
					end else if (MEM_ACK_I) begin
						MEM_O.req <= 1'b0;
						sar_r <= sar_step;
						dar_r <= dar_step;
						elem_r <= elem_r - 9'h001;
						if (elem_r != 9'h001) begin
							state_r <= bcte_pkg::S_DRD;
						end else begin
							hit_r <= count_hit;
							if (area_wrap) begin
								if (mrb_r.area_side_select)
									sar_r <= sar0_r;
								else
									dar_r <= dar0_r;
							end
							case (md)
								`BCTE_MD_BLOCK: begin
									cra_r[7:0] <= count_a_reload;
									crb_r <= crb_r - 16'h0001;
								end
								`BCTE_MD_REPEAT: cra_r[7:0] <= (count_a_low == 8'h01) ? count_a_reload : count_a_low - 8'h01;
								default: cra_r <= cra_r - 16'h0001;
							endcase
							int_cnt_r <= 2'h0;
							idx_r <= 2'h0;
							state_r <= skip_r ? bcte_pkg::S_WB : bcte_pkg::S_INT;
						end
					end
				end
				bcte_pkg::S_INT: begin
					int_cnt_r <= int_cnt_r + 2'h1;
					if (int_cnt_r == `BCTE_INT_CYCLES - 2'h1)
						state_r <= bcte_pkg::S_WB;
				end
				bcte_pkg::S_WB: begin
					if (!MEM_O.req) begin
						case (idx_r)
							2'h0: begin
								if (mra_r.source_addr_mode[1] == 1'b0)
									idx_r <= 2'h1;
								else
									MEM_O <= {1'b1, 1'b1, 1'b1, `BCTE_SZ_LONG, short_mode ? info_base_r
										: info_base_r + `BCTE_FULL_WB_BASE,
										short_mode ? {mra_r, sar_r[23:0]} : sar_r};
							end
							2'h1: begin
								if (mrb_r.dest_addr_mode[1] == 1'b0)
									idx_r <= 2'h2;
								else
									MEM_O <= {1'b1, 1'b1, 1'b1, `BCTE_SZ_LONG, info_base_r
										+ (short_mode ? `BCTE_SHORT_WB_DAR : `BCTE_FULL_WB_DAR),
										short_mode ? {mrb_r, dar_r[23:0]} : dar_r};
							end
							default: MEM_O <= {1'b1, 1'b1, 1'b1, `BCTE_SZ_LONG, info_base_r
								+ (short_mode ? `BCTE_SHORT_WB_CNT : `BCTE_FULL_WB_CNT), cra_r, crb_r};
						endcase
					end else if (MEM_ACK_I) begin
						MEM_O <= '0;
						if (idx_r != `BCTE_WB_LAST) begin
							idx_r <= idx_r + 2'h1;
						end else if (link_go) begin
							chained_r <= 1'b1;
							skip_r <= 1'b0;
							idx_r <= 2'h0;
							info_base_r <= info_base_r + (short_mode ? `BCTE_SHORT_STRIDE
								: `BCTE_FULL_STRIDE);
							state_r <= bcte_pkg::S_INFO;
						end else begin
							CPU_IRQ_O <= end_irq;
							FLAG_CLR_O <= !end_irq;
							prev_vec_r <= cur_vec_r;
							prev_ok_r <= ctrl_r[`BCTE_CTRL_RRS] && !chained_r
								&& !(hit_r && md != `BCTE_MD_REPEAT);
							elem_r <= 9'h0;
							state_r <= bcte_pkg::S_IDLE;
						end
					end
				end
				default: state_r <= bcte_pkg::S_IDLE;
			endcase
		end
	end
endmodule : bcte_engine

// ==== hw/bcte_params.svh ====
// Constants of the block chain transfer engine: register offsets, field codes and counts.
// Assumes inclusion by bare name; definitions only.
`ifndef BCTE_PARAMS_SVH
`define BCTE_PARAMS_SVH
`define BCTE_REG_VTB 8'h00
`define BCTE_REG_CTRL 8'h04
`define BCTE_REG_STAT 8'h08
`define BCTE_CTRL_RUN 0
`define BCTE_CTRL_RRS 1
`define BCTE_CTRL_SHORT 2
`define BCTE_MD_NORMAL 2'h0
`define BCTE_MD_REPEAT 2'h1
`define BCTE_MD_BLOCK 2'h2
`define BCTE_AM_INC 2'h2
`define BCTE_AM_DEC 2'h3
`define BCTE_SZ_BYTE 2'h0
`define BCTE_SZ_WORD 2'h1
`define BCTE_SZ_LONG 2'h2
`define BCTE_STEP_BYTE 32'h1
`define BCTE_STEP_WORD 32'h2
`define BCTE_STEP_LONG 32'h4
`define BCTE_FULL_LAST 2'h3
`define BCTE_SHORT_LAST 2'h2
`define BCTE_WB_LAST 2'h2
`define BCTE_FULL_STRIDE 32'h10
`define BCTE_SHORT_STRIDE 32'hC
`define BCTE_FULL_WB_BASE 32'h4
`define BCTE_SHORT_WB_DAR 32'h4
`define BCTE_FULL_WB_DAR 32'h8
`define BCTE_SHORT_WB_CNT 32'h8
`define BCTE_FULL_WB_CNT 32'hC
`define BCTE_INT_CYCLES 2'h2
`define BCTE_BLK_FULL 9'h100
`define BCTE_ALIGN_MASK 32'hFFFFFFFC
`endif

// ==== hw/bcte_pkg.sv ====
// Types of the block chain transfer engine: states, mode words and the bus request.
// Constants live in bcte_params.svh.
package bcte_pkg;
	typedef enum logic [3:0] {
		S_IDLE = 4'h0,
		S_VEC = 4'h1,
		S_INFO = 4'h2,
		S_GAP = 4'h3,
		S_DRD = 4'h4,
		S_DWR = 4'h5,
		S_INT = 4'h6,
		S_WB = 4'h7
	} bcte_state_t;
	typedef struct packed {
		logic [1:0] transfer_mode_field;
		logic [1:0] element_size;
		logic [1:0] source_addr_mode;
		logic [1:0] rsv;
	} bcte_mra_t;
	typedef struct packed {
		logic link_enable;
		logic link_on_zero;
		logic irq_every_transfer;
		logic area_side_select;
		logic [1:0] dest_addr_mode;
		logic [1:0] rsv;
	} bcte_mrb_t;
	typedef struct packed {
		logic req;
		logic we;
		logic lock;
		logic [1:0] size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} bcte_bus_t;
endpackage : bcte_pkg

// ==== bench/bcte_engine_chk.sv ====
// Checker of the transfer engine: bus handshake, element data path and end pulses.
// Bound to bcte_engine and sees only its ports.
`timescale 1ns/1ns
module bcte_engine_chk (
	// Clock and reset
	input wire logic CLOCK_I,
	input wire logic RST_B_I,
	// Register port
	input wire logic [7:0] REG_ADDR_I,
	input wire logic [31:0] REG_WDATA_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	input wire logic [31:0] REG_RDATA_O,
	// Startup requests and system bus
	input wire logic STARTUP_REQ_I,
	input wire logic [7:0] VECTOR_I,
	input wire logic REQ_FULL_O,
	input wire bcte_pkg::bcte_bus_t MEM_O,
	input wire logic MEM_ACK_I,
	input wire logic [31:0] MEM_RDATA_I,
	// Interrupt source handling
	input wire logic CPU_IRQ_O,
	input wire logic FLAG_CLR_O
);
	logic [31:0] dat_r;
	default clocking chk_cb @(posedge CLOCK_I); endclocking
	default disable iff (!RST_B_I);
	// The last element read is what the following element write has to carry.
	always_ff @(posedge CLOCK_I) begin
		if (!RST_B_I) begin
			dat_r <= 32'h0;
		end else if (MEM_ACK_I && !MEM_O.we && !MEM_O.lock) begin
			dat_r <= MEM_RDATA_I;
		end
	end
	chk_req_held: assert property (MEM_O.req && !MEM_ACK_I |=> MEM_O.req && $stable(MEM_O))
		else $error("bus request changed before its acknowledge");
	chk_ack_release: assert property (MEM_ACK_I |=> !MEM_O.req)
		else $error("bus request kept after acknowledge");
	chk_move_order: assert property (MEM_ACK_I && !MEM_O.we && !MEM_O.lock
		|-> ##[2:4] (MEM_O.req && MEM_O.we && !MEM_O.lock))
		else $error("element read not followed by its write");
	chk_move_data: assert property ($rose(MEM_O.req) && MEM_O.we && !MEM_O.lock
		&& MEM_O.size == 2'h2 |-> MEM_O.wdata == dat_r)
		else $error("element write data differs from data read");
	chk_irq_pulse: assert property (CPU_IRQ_O |=> !CPU_IRQ_O)
		else $error("interrupt longer than one cycle");
	chk_end_single: assert property (!(CPU_IRQ_O && FLAG_CLR_O))
		else $error("interrupt and flag clear together");
	chk_pend_hold: assert property (!STARTUP_REQ_I && !REQ_FULL_O |=> !REQ_FULL_O)
		else $error("pending slot filled without a request");
	chk_pend_set: assert property (STARTUP_REQ_I && MEM_O.req && !MEM_ACK_I |=> REQ_FULL_O)
		else $error("request during a transfer not held pending");
	chk_rdata_quiet: assert property (REG_RDATA_O != 32'h0 |-> $past(REG_RD_I))
		else $error("read data outside the read answer cycle");
	cov_irq: cover property (CPU_IRQ_O);
	cov_flag: cover property (FLAG_CLR_O);
	cov_pend: cover property (STARTUP_REQ_I && REQ_FULL_O);
endmodule : bcte_engine_chk
bind bcte_engine bcte_engine_chk u_chk (.CLOCK_I(CLOCK_I), .RST_B_I(RST_B_I),
	.REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I),
	.REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O), .STARTUP_REQ_I(STARTUP_REQ_I),
	.VECTOR_I(VECTOR_I), .REQ_FULL_O(REQ_FULL_O), .MEM_O(MEM_O), .MEM_ACK_I(MEM_ACK_I),
	.MEM_RDATA_I(MEM_RDATA_I), .CPU_IRQ_O(CPU_IRQ_O), .FLAG_CLR_O(FLAG_CLR_O));

// ==== bench/bcte_mem_model.sv ====
// Memory and arbiter model on the far side of the engine's system bus.
// Word array over addresses 0x000 to 0x3FF; every request is granted after dly_i cycles.
`timescale 1ns/1ns
module bcte_mem_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Answer delay
	input wire logic [3:0] dly_i,
	// Bus
	input wire bcte_pkg::bcte_bus_t bus_i,
	output logic ack_o,
	output logic [31:0] rdata_o
);
	logic [31:0] mem [0:255];
	logic [3:0] cnt_r;
	int n_ack;
	// Read data is inverted every idle cycle so that stale data is never mistaken for an answer.
	always @(posedge clk_i) begin
		ack_o <= 1'b0;
		rdata_o <= ~rdata_o;
		if (!rst_b_i) begin
			cnt_r <= 4'h0;
			n_ack <= 0;
			rdata_o <= 32'hA5A5A5A5;
		end else if (bus_i.req && !ack_o) begin
			if (cnt_r == dly_i) begin
				ack_o <= 1'b1;
				cnt_r <= 4'h0;
				n_ack <= n_ack + 1;
				if (bus_i.we) begin
					mem[bus_i.addr[9:2]] <= bus_i.wdata;
				end else begin
					rdata_o <= mem[bus_i.addr[9:2]];
				end
			end else begin
				cnt_r <= cnt_r + 4'h1;
			end
		end
	end
endmodule : bcte_mem_model

// ==== bench/bcte_engine_bench.sv ====
// Testbench of the transfer engine: register setup, block, chained, pending and skip runs.
// Assumes the memory model holds all transfer information and element data.
`timescale 1ns/1ns
module bcte_engine_bench;
	logic clock, rst_b, reg_wr, reg_rd, startup, ack, irq, flag_clr, req_full;
	logic [7:0] reg_addr, vector;
	logic [31:0] reg_wdata, reg_rdata, mem_rdata;
	logic [3:0] dly;
	bcte_pkg::bcte_bus_t mem_bus;
	int n_errors, total_checks, acks;
	bcte_engine DUT (.CLOCK_I(clock), .RST_B_I(rst_b), .REG_ADDR_I(reg_addr),
		.REG_WDATA_I(reg_wdata), .REG_WR_I(reg_wr), .REG_RD_I(reg_rd), .REG_RDATA_O(reg_rdata),
		.STARTUP_REQ_I(startup), .VECTOR_I(vector), .REQ_FULL_O(req_full), .MEM_O(mem_bus),
		.MEM_ACK_I(ack), .MEM_RDATA_I(mem_rdata), .CPU_IRQ_O(irq), .FLAG_CLR_O(flag_clr));
	bcte_mem_model MEM (.clk_i(clock), .rst_b_i(rst_b), .dly_i(dly), .bus_i(mem_bus),
		.ack_o(ack), .rdata_o(mem_rdata));
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check
	task automatic end_sim;
		if (n_errors == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_sim
	task automatic reg_access(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= wr;
		reg_rd <= !wr;
		@(posedge clock);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		#1;
		if (!wr) begin
			check(reg_rdata, d, "register read");
		end
	endtask : reg_access
	task automatic start(input logic [7:0] v);
		@(posedge clock);
		startup <= 1'b1;
		vector <= v;
		@(posedge clock);
		startup <= 1'b0;
	endtask : start
	// Waits for the end pulse of one startup and checks whether it went to the CPU.
	task automatic wait_end(input logic exp_irq);
		int i = 0;
		#1;
		while (irq !== 1'b1 && flag_clr !== 1'b1) begin
			@(posedge clock);
			#1;
			i++;
			if (i > 3000) begin
				n_errors++;
				end_sim();
			end
		end
		check({31'h0, irq}, {31'h0, exp_irq}, "end pulse kind");
		@(posedge clock);
	endtask : wait_end
	task automatic put4(input logic [7:0] w, input logic [31:0] a, b, c, d);
		MEM.mem[w] = a;
		MEM.mem[w + 8'h1] = b;
		MEM.mem[w + 8'h2] = c;
		MEM.mem[w + 8'h3] = d;
	endtask : put4
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	initial begin
		{rst_b, reg_wr, reg_rd, startup, reg_addr, vector, reg_wdata, dly} = '0;
		n_errors = 0;
		total_checks = 0;
		for (int i = 0; i < 6; i++) begin
			MEM.mem[8'hC0 + i] = 32'h10000000 + i;
		end
		MEM.mem[8'h40] = 32'h200;
		MEM.mem[8'h42] = 32'h280;
		MEM.mem[8'h43] = 32'h2C0;
		put4(8'h80, 32'hA8080000, 32'h300, 32'h340, 32'h03030002);
		put4(8'hA0, 32'h20A80000, 32'h300, 32'h3A0, 32'h00050000);
		put4(8'hA4, 32'h28000000, 32'h304, 32'h3B0, 32'h00040000);
		put4(8'hB0, 32'h20000000, 32'h310, 32'h3C0, 32'h00000000);
		// Short form: a repeat set over the source area that chains to a normal set on reload.
		MEM.mem[8'h44] = 32'h240;
		put4(8'h90, 32'h68000300, 32'hDC0003F0, 32'h02020000, 32'h20000314);
		MEM.mem[8'h94] = 32'h280003D0;
		MEM.mem[8'h95] = 32'h00070000;
		repeat (6) @(posedge clock);
		rst_b <= 1'b1;
		reg_access(1'b1, 8'h00, 32'h103);
		reg_access(1'b0, 8'h00, 32'h100);
		reg_access(1'b1, 8'h04, 32'h1);
		reg_access(1'b0, 8'h04, 32'h1);
		reg_access(1'b0, 8'h0C, 32'h0);
		// Block mode, three longwords a block, two blocks, prompt memory.
		start(8'h00);
		wait_end(1'b0);
		check(MEM.mem[8'h81], 32'h30C, "free address after block");
		check(MEM.mem[8'h82], 32'h340, "block area restored");
		check(MEM.mem[8'h83], 32'h03030001, "block counts");
		start(8'h00);
		wait_end(1'b1);
		for (int i = 0; i < 3; i++) begin
			check(MEM.mem[8'hD0 + i], 32'h10000003 + i, "block element");
		end
		check(MEM.mem[8'h83], 32'h03030000, "last block count");
		// Two chained sets, second startup arrives mid-transfer, slow memory.
		dly <= 4'h3;
		start(8'h02);
		repeat (4) @(posedge clock);
		start(8'h02);
		#1 check({31'h0, req_full}, 32'h1, "pending slot");
		wait_end(1'b0);
		wait_end(1'b0);
		check(MEM.mem[8'hE9], 32'h10000000, "fixed source element");
		check(MEM.mem[8'hA1], 32'h300, "fixed source kept");
		check(MEM.mem[8'hA2], 32'h3A8, "first set destination");
		check(MEM.mem[8'hA3], 32'h00030000, "first set count");
		check(MEM.mem[8'hEC], 32'h10000002, "fixed destination element");
		check(MEM.mem[8'hA5], 32'h30C, "second set source");
		check(MEM.mem[8'hA7], 32'h00020000, "second set count");
		// Count zero as 65536, then the same vector again with reread skip on.
		dly <= 4'h1;
		reg_access(1'b1, 8'h04, 32'h3);
		acks = MEM.n_ack;
		start(8'h03);
		wait_end(1'b0);
		check(32'(MEM.n_ack - acks), 32'h8, "full fetch accesses");
		check(MEM.mem[8'hB3], 32'hFFFF0000, "count after zero");
		acks = MEM.n_ack;
		start(8'h03);
		wait_end(1'b0);
		check(32'(MEM.n_ack - acks), 32'h3, "skipped fetch accesses");
		check(MEM.mem[8'hF0], 32'h10000004, "normal element");
		check(MEM.mem[8'hB3], 32'hFFFE0000, "count after skip");
		// Short form, repeat over a source area with a decrementing destination, chain on reload.
		reg_access(1'b1, 8'h04, 32'h5);
		acks = MEM.n_ack;
		start(8'h04);
		wait_end(1'b0);
		check(32'(MEM.n_ack - acks), 32'h9, "short fetch accesses");
		check(MEM.mem[8'hFC], 32'h10000000, "repeat first element");
		check(MEM.mem[8'h91], 32'hDC0003EC, "decremented destination");
		check(MEM.mem[8'h92], 32'h02010000, "repeat count");
		start(8'h04);
		wait_end(1'b1);
		check(MEM.mem[8'h90], 32'h68000300, "repeat area restored");
		check(MEM.mem[8'h92], 32'h02020000, "repeat count reloaded");
		check(MEM.mem[8'hFB], 32'h10000001, "repeat element");
		check(MEM.mem[8'hF4], 32'h10000005, "chained set element");
		check(MEM.mem[8'h94], 32'h280003D4, "chained set destination");
		check(MEM.mem[8'h95], 32'h00060000, "chained set count");
		reg_access(1'b0, 8'h08, 32'h404);
		end_sim();
	end
endmodule : bcte_engine_bench
